// ==== common/acd_pkg.sv ====
/*
 * Shared constants and types of the clock detector status block: register
 * address and layout, clock rates, detection limits and counter widths.
 * Assumes a 40 MHz device clock and an 8-bit register access port.
 */
package acd_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] CLK_DET_STATUS_ADDR = 8'h5e;
    localparam logic       RSVD_RESET          = 1'b0;
    localparam logic [7:0] UNMAPPED_READ       = 8'h00;

    // Layout of the status register, bit 7 down to bit 0.
    typedef struct packed {
        logic reserved;
        logic master_clock_halted;
        logic pll_unlocked;
        logic serial_clocks_missing;
        logic auto_setup_combination_error;
        logic master_clock_invalid;
        logic bit_clock_invalid;
        logic sample_rate_invalid;
    } acd_status_t;

    // =====================================================================
    // Clock and timing
    // =====================================================================
    localparam int CLK_HZ          = 40_000_000;
    localparam int FS_MIN_HZ       = 8_000;
    localparam int FS_MAX_HZ       = 384_000;
    localparam int MCLK_HALT_NS    = 1_000;
    localparam int SERIAL_HALT_NS  = 10_000;
    // Longest valid frame rounds down, shortest rounds up.
    localparam int FRAME_MAX_CYC   = CLK_HZ / FS_MIN_HZ;
    localparam int FRAME_MIN_CYC   = (CLK_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ;
    localparam int MCLK_HALT_CYC   = (MCLK_HALT_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int SERIAL_HALT_CYC = (SERIAL_HALT_NS * (CLK_HZ / 1_000_000)) / 1_000;

    // =====================================================================
    // Detection limits and widths
    // =====================================================================
    localparam int FRAME_CNT_W = 16;
    localparam int BIT_CNT_W   = 10;
    localparam int RATIO_W     = 12;
    localparam int ACT_CNT_W   = 16;

    localparam logic [BIT_CNT_W-1:0] LOW_SHORT_BITS = 10'h005;
    localparam logic [BIT_CNT_W-1:0] BCK_RATIO_MIN  = 10'h020;
    localparam logic [BIT_CNT_W-1:0] BCK_RATIO_MAX  = 10'h100;
    localparam logic [RATIO_W-1:0]   RATIO_TOL      = 12'h002;
    localparam logic [RATIO_W-1:0]   AUTO_MIN_RATIO = 12'h080;

    localparam int NUM_RATIOS = 13;
    localparam logic [RATIO_W-1:0] MCLK_RATIOS [NUM_RATIOS] = '{
        12'h020, 12'h030, 12'h040, 12'h080, 12'h0c0, 12'h100, 12'h180,
        12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800
    };

    // One frame measured in the bit clock domain.
    typedef struct packed {
        logic [BIT_CNT_W-1:0] bits_per_frame;
        logic                 low_short;
    } acd_frame_meas_t;

endpackage : acd_pkg

// ==== hw/acd_activity.sv ====
/*
 * Pin activity watcher: synchroniser, edge detector and idle timeout.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module acd_activity #(
    parameter int TIMEOUT = 40
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      active
);

    // =====================================================================
    // Synchroniser and timeout
    // =====================================================================
    logic                         sync1_ff;
    logic                         sync2_ff;
    logic                         dly_ff;
    logic [acd_pkg::ACT_CNT_W-1:0] idle_ff;
    logic [acd_pkg::ACT_CNT_W-1:0] nxt_idle;
    logic                         edge_seen;

    always_comb begin
        edge_seen = sync2_ff ^ dly_ff;
        nxt_idle  = idle_ff;
        if (edge_seen) begin
            nxt_idle = '0;
        end else if (idle_ff < acd_pkg::ACT_CNT_W'(TIMEOUT)) begin
            nxt_idle = idle_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        sync1_ff <= pin;
        sync2_ff <= sync1_ff;
        if (srst) begin
            dly_ff  <= 1'b0;
            idle_ff <= acd_pkg::ACT_CNT_W'(TIMEOUT);
        end else begin
            dly_ff  <= sync2_ff;
            idle_ff <= nxt_idle;
        end
    end

    assign level  = sync2_ff;
    assign rise   = sync2_ff & ~dly_ff;
    assign active = idle_ff < acd_pkg::ACT_CNT_W'(TIMEOUT);

endmodule : acd_activity

`default_nettype wire

// ==== hw/acd_word_sync.sv ====
/*
 * Word crossing by toggle handshake; a send while busy is dropped.
 * Assumes src_data is valid with src_send.
 */
`timescale 1ns/100ps
`default_nettype none

module acd_word_sync #(
    parameter int W = 8
) (
    input  wire logic         src_clk,
    input  wire logic         src_srst,
    input  wire logic         src_send,
    input  wire logic [W-1:0] src_data,
    input  wire logic         dst_clk,
    input  wire logic         dst_srst,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);

    // =====================================================================
    // Source side
    // =====================================================================
    logic         req_ff;
    logic         ack_s1_ff;
    logic         ack_s2_ff;
    logic         dst_ack_ff;
    logic [W-1:0] hold_ff;
    logic         nxt_req;
    logic [W-1:0] nxt_hold;
    logic         take;

    always_comb begin
        take     = src_send & (req_ff == ack_s2_ff);
        nxt_req  = take ? ~req_ff : req_ff;
        nxt_hold = take ? src_data : hold_ff;
    end

    always_ff @(posedge src_clk) begin
        ack_s1_ff <= dst_ack_ff;
        ack_s2_ff <= ack_s1_ff;
        if (src_srst) begin
            req_ff  <= 1'b0;
            hold_ff <= '0;
        end else begin
            req_ff  <= nxt_req;
            hold_ff <= nxt_hold;
        end
    end

    // =====================================================================
    // Destination side
    // =====================================================================
    logic         req_s1_ff;
    logic         req_s2_ff;
    logic         valid_ff;
    logic [W-1:0] data_ff;
    logic         nxt_valid;
    logic [W-1:0] nxt_data;

    always_comb begin
        nxt_valid = req_s2_ff ^ dst_ack_ff;
        nxt_data  = nxt_valid ? hold_ff : data_ff;
    end

    always_ff @(posedge dst_clk) begin
        req_s1_ff <= req_ff;
        req_s2_ff <= req_s1_ff;
        if (dst_srst) begin
            dst_ack_ff <= 1'b0;
            valid_ff   <= 1'b0;
            data_ff    <= '0;
        end else begin
            dst_ack_ff <= req_s2_ff;
            valid_ff   <= nxt_valid;
            data_ff    <= nxt_data;
        end
    end

    assign dst_valid = valid_ff;
    assign dst_data  = data_ff;

endmodule : acd_word_sync

`default_nettype wire

// ==== hw/acd_clock_status.sv ====
/*
 * Clock detector status register of a digital-input audio amplifier.
 * Shows master, bit and frame clock and PLL state as live flags.
 *
 * Assumes a 40 MHz CLK, the bit clock on its own port BCK
 * and a plain register port from the control interface.
 */
// Functional notes
// RULE_01 - Bit 6 reads 1 while the master clock is halted and 0 while it runs.
// RULE_02 - Bit 5 reads 1 unless the PLL is enabled and locked.
// RULE_03 - Bit 4 reads 1 only while frame clock and bit clock are both absent and low.
// RULE_04 - Bit 3 reads 1 when rate and master clock ratio rule out automatic clock setup.
// RULE_05 - Bit 2 reads 1 whenever the master clock ratio cannot be detected.
// RULE_06 - Bit 2 also reads 1 when the frame clock low phase lasts five bit clocks or fewer.
// RULE_07 - Bit 1 reads 0 only while the bit clock ratio is stable and within 32 to 256.
// RULE_08 - Bit 0 reads 1 whenever no detectable sample rate is present.
// RULE_09 - Bit 0 is cleared while the error-ignore configuration lets the converter recover.
// RULE_10 - Status bits follow the detectors live, ignore writes and are not cleared by reads; the code keeps writes to reserved bit 7.
`timescale 1ns/100ps
`default_nettype none

module acd_clock_status #(
    parameter int FRAME_MAX_CYC = acd_pkg::FRAME_MAX_CYC
) (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       BCK,
    input  wire logic       LRCK_PIN,
    input  wire logic       MCLK_PIN,
    input  wire logic       PLL_ENABLE,
    input  wire logic       PLL_LOCKED,
    input  wire logic       ERROR_IGNORE_CONFIG,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WE,
    input  wire logic       REG_RE,
    input  wire logic [7:0] REG_WDATA,
    output logic [7:0]      REG_RDATA
);

    localparam int MEAS_W      = $bits(acd_pkg::acd_frame_meas_t);
    localparam int LRCK_TMO    = FRAME_MAX_CYC + FRAME_MAX_CYC / 4;

    // =====================================================================
    // Bit clock domain: reset and frame clock synchronisers
    // =====================================================================
    logic lrst_s1_ff;
    logic lrst_ff;
    logic lk_s1_ff;
    logic lk_s2_ff;
    logic lk_d_ff;

    always_ff @(posedge BCK) begin
        lrst_s1_ff <= SRST;
        lrst_ff    <= lrst_s1_ff;
        lk_s1_ff   <= LRCK_PIN;
        lk_s2_ff   <= lk_s1_ff;
    end

    // =====================================================================
    // Bit clock domain: bits per frame and low phase length
    // =====================================================================
    logic [acd_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
    logic [acd_pkg::BIT_CNT_W-1:0] low_cnt_ff;
    logic [acd_pkg::BIT_CNT_W-1:0] nxt_bit_cnt;
    logic [acd_pkg::BIT_CNT_W-1:0] nxt_low_cnt;
    logic                          nxt_lk_d;
    logic                          lk_rise;
    acd_pkg::acd_frame_meas_t      link_meas;

    always_comb begin
        lk_rise     = lk_s2_ff & ~lk_d_ff;
        nxt_lk_d    = lk_s2_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_low_cnt = low_cnt_ff;
        if (lk_rise) begin
            nxt_bit_cnt = acd_pkg::BIT_CNT_W'(1);
            nxt_low_cnt = '0;
        end else begin
            if (~&bit_cnt_ff) begin
                nxt_bit_cnt = bit_cnt_ff + 1'b1;
            end
            if (~lk_s2_ff && ~&low_cnt_ff) begin
                nxt_low_cnt = low_cnt_ff + 1'b1;
            end
        end
        link_meas.bits_per_frame = bit_cnt_ff;
        link_meas.low_short      = low_cnt_ff <= acd_pkg::LOW_SHORT_BITS; // RULE_06
    end

    always_ff @(posedge BCK) begin
        if (lrst_ff) begin
            lk_d_ff    <= 1'b0;
            bit_cnt_ff <= '0;
            low_cnt_ff <= '0;
        end else begin
            lk_d_ff    <= nxt_lk_d;
            bit_cnt_ff <= nxt_bit_cnt;
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    // =====================================================================
    // Crossing of each frame measurement into the device clock domain
    // =====================================================================
    logic              meas_valid;
    logic [MEAS_W-1:0] meas_bits;

    acd_word_sync #(
        .W(MEAS_W)
    ) u_meas_sync (
        .src_clk  (BCK),
        .src_srst (lrst_ff),
        .src_send (lk_rise),
        .src_data (link_meas),
        .dst_clk  (CLK),
        .dst_srst (SRST),
        .dst_valid(meas_valid),
        .dst_data (meas_bits)
    );

    // =====================================================================
    // Pin activity in the device clock domain
    // =====================================================================
    logic mclk_rise;
    logic mclk_active;
    logic bck_level;
    logic bck_active;
    logic lrck_level;
    logic lrck_rise;
    logic lrck_active;

    acd_activity #(
        .TIMEOUT(acd_pkg::MCLK_HALT_CYC)
    ) u_mclk_act (
        .clk   (CLK),
        .srst  (SRST),
        .pin   (MCLK_PIN),
        .level (),
        .rise  (mclk_rise),
        .active(mclk_active)
    );

    acd_activity #(
        .TIMEOUT(acd_pkg::SERIAL_HALT_CYC)
    ) u_bck_act (
        .clk   (CLK),
        .srst  (SRST),
        .pin   (BCK),
        .level (bck_level),
        .rise  (),
        .active(bck_active)
    );

    acd_activity #(
        .TIMEOUT(LRCK_TMO)
    ) u_lrck_act (
        .clk   (CLK),
        .srst  (SRST),
        .pin   (LRCK_PIN),
        .level (lrck_level),
        .rise  (lrck_rise),
        .active(lrck_active)
    );

    // =====================================================================
    // Frame period and master clock count per frame
    // =====================================================================
    logic [acd_pkg::FRAME_CNT_W-1:0] frame_cnt_ff;
    logic [acd_pkg::FRAME_CNT_W-1:0] period_ff;
    logic [acd_pkg::RATIO_W-1:0]     mclk_cnt_ff;
    logic [acd_pkg::RATIO_W-1:0]     ratio_ff;
    logic [acd_pkg::FRAME_CNT_W-1:0] nxt_frame_cnt;
    logic [acd_pkg::FRAME_CNT_W-1:0] nxt_period;
    logic [acd_pkg::RATIO_W-1:0]     nxt_mclk_cnt;
    logic [acd_pkg::RATIO_W-1:0]     nxt_ratio;

    always_comb begin
        nxt_frame_cnt = frame_cnt_ff;
        nxt_period    = period_ff;
        nxt_mclk_cnt  = mclk_cnt_ff;
        nxt_ratio     = ratio_ff;
        if (lrck_rise) begin
            nxt_period    = frame_cnt_ff;
            nxt_ratio     = mclk_cnt_ff;
            nxt_frame_cnt = acd_pkg::FRAME_CNT_W'(1);
            nxt_mclk_cnt  = mclk_rise ? acd_pkg::RATIO_W'(1) : '0;
        end else begin
            if (~&frame_cnt_ff) begin
                nxt_frame_cnt = frame_cnt_ff + 1'b1;
            end
            if (mclk_rise && ~&mclk_cnt_ff) begin
                nxt_mclk_cnt = mclk_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            frame_cnt_ff <= '0;
            period_ff    <= '0;
            mclk_cnt_ff  <= '0;
            ratio_ff     <= '0;
        end else begin
            frame_cnt_ff <= nxt_frame_cnt;
            period_ff    <= nxt_period;
            mclk_cnt_ff  <= nxt_mclk_cnt;
            ratio_ff     <= nxt_ratio;
        end
    end

    // =====================================================================
    // Bit clock ratio history
    // =====================================================================
    acd_pkg::acd_frame_meas_t      meas_ff;
    acd_pkg::acd_frame_meas_t      nxt_meas;
    logic [acd_pkg::BIT_CNT_W-1:0] prev_bits_ff;
    logic [acd_pkg::BIT_CNT_W-1:0] nxt_prev_bits;

    always_comb begin
        nxt_meas      = meas_ff;
        nxt_prev_bits = prev_bits_ff;
        if (meas_valid) begin
            nxt_meas      = meas_bits;
            nxt_prev_bits = meas_ff.bits_per_frame;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            meas_ff      <= '0;
            prev_bits_ff <= '0;
        end else begin
            meas_ff      <= nxt_meas;
            prev_bits_ff <= nxt_prev_bits;
        end
    end

    // =====================================================================
    // Status flags and register access
    // =====================================================================
    acd_pkg::acd_status_t status_ff;
    acd_pkg::acd_status_t nxt_status;
    logic [7:0]           rdata_ff;
    logic [7:0]           nxt_rdata;
    logic                 ratio_match;
    logic                 rate_bad;
    logic [acd_pkg::RATIO_W-1:0] diff;

    always_comb begin
        ratio_match = 1'b0;
        diff        = '0;
        for (int i = 0; i < acd_pkg::NUM_RATIOS; i++) begin
            diff = (ratio_ff > acd_pkg::MCLK_RATIOS[i]) ? ratio_ff - acd_pkg::MCLK_RATIOS[i]
                                                        : acd_pkg::MCLK_RATIOS[i] - ratio_ff;
            if (diff <= acd_pkg::RATIO_TOL) begin
                ratio_match = 1'b1;
            end
        end
        rate_bad = ~lrck_active
                 | (period_ff < acd_pkg::FRAME_CNT_W'(acd_pkg::FRAME_MIN_CYC))
                 | (period_ff > acd_pkg::FRAME_CNT_W'(FRAME_MAX_CYC)); // RULE_08

        nxt_status          = status_ff;
        if (REG_WE && REG_ADDR == acd_pkg::CLK_DET_STATUS_ADDR) begin
            nxt_status.reserved = REG_WDATA[7]; // RULE_10
        end
        nxt_status.master_clock_halted   = ~mclk_active; // RULE_01
        nxt_status.pll_unlocked          = ~(PLL_ENABLE & PLL_LOCKED); // RULE_02
        nxt_status.serial_clocks_missing = ~bck_active & ~lrck_active
                                         & ~bck_level & ~lrck_level; // RULE_03
        nxt_status.master_clock_invalid  = ~mclk_active | ~lrck_active | ~ratio_match // RULE_05
                                         | meas_ff.low_short; // RULE_06
        nxt_status.auto_setup_combination_error = rate_bad | ~mclk_active | ~ratio_match
                                         | (~PLL_ENABLE & (ratio_ff < acd_pkg::AUTO_MIN_RATIO)); // RULE_04
        nxt_status.bit_clock_invalid     = ~bck_active | ~lrck_active
                                         | (meas_ff.bits_per_frame != prev_bits_ff)
                                         | (meas_ff.bits_per_frame < acd_pkg::BCK_RATIO_MIN)
                                         | (meas_ff.bits_per_frame > acd_pkg::BCK_RATIO_MAX); // RULE_07
        nxt_status.sample_rate_invalid   = rate_bad & ~ERROR_IGNORE_CONFIG; // RULE_09

        nxt_rdata = rdata_ff;
        if (REG_RE) begin
            if (REG_ADDR == acd_pkg::CLK_DET_STATUS_ADDR) begin
                nxt_rdata = status_ff; // RULE_10
            end else begin
                nxt_rdata = acd_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            status_ff <= '{reserved: acd_pkg::RSVD_RESET, default: 1'b1};
            rdata_ff  <= '0;
        end else begin
            status_ff <= nxt_status;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign REG_RDATA = rdata_ff;

endmodule : acd_clock_status

`default_nettype wire

// ==== tb/acd_source_model.sv ====
/*
 * Audio source model: bit, frame and master clocks.
 * Assumes the bench sets frame shape and enables.
 */
`timescale 1ns/100ps
`default_nettype none

module acd_source_model (
    input  wire logic run,
    input  wire logic mclk_on,
    input  var  int   bits,
    input  var  int   mratio,
    input  var  int   low,
    output logic      bck,
    output logic      lrck,
    output logic      mclk
);
    // =====================================================================
    // Clocks
    // =====================================================================
    // Serial clocks rest low while stopped.
    initial begin
        {bck, lrck} = 2'b00;
        #3;
        forever begin
            if (!run) begin
                {bck, lrck} = 2'b00;
                #16;
            end else begin
                for (int i = 0; i < bits; i++) begin
                    lrck = (i < bits - low);
                    #16 bck = 1'b1;
                    #16 bck = 1'b0;
                end
            end
        end
    end

    // The master clock runs at mratio times the frame rate.
    initial begin
        mclk = 1'b0;
        forever begin
            if (mclk_on) #(bits * 16.0 / mratio) mclk = ~mclk;
            else #10 mclk = 1'b0;
        end
    end
endmodule : acd_source_model

`default_nettype wire

// ==== tb/acd_clock_status_asserts.sv ====
/*
 * Checker of the clock status block.
 * Assumes the top module's ports, sampled on CLK.
 */
`timescale 1ns/100ps
`default_nettype none

module acd_clock_status_asserts #(
    parameter int FRAME_MAX_CYC = 5000
) (
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       BCK,
    input wire logic       LRCK_PIN,
    input wire logic       MCLK_PIN,
    input wire logic       PLL_ENABLE,
    input wire logic       PLL_LOCKED,
    input wire logic       ERROR_IGNORE_CONFIG,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WE,
    input wire logic       REG_RE,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA
);
    // =====================================================================
    // Pin activity counters
    // =====================================================================
    localparam int QUIET_MIN = 2 * FRAME_MAX_CYC + 500;
    localparam logic [7:0] SA = acd_pkg::CLK_DET_STATUS_ADDR;
    logic [15:0] m_idle_ff, m_run_ff, b_idle_ff, b_run_ff, quiet_ff;
    logic        m_d_ff, b_d_ff;
    logic        rd_st;

    function automatic logic [15:0] inc(input logic [15:0] c);
        return (c == 16'hffff) ? c : c + 16'h0001;
    endfunction : inc

    assign rd_st = REG_RE && REG_ADDR == SA;

    always_ff @(posedge CLK) begin
        m_d_ff    <= MCLK_PIN;
        b_d_ff    <= BCK;
        m_idle_ff <= (SRST || MCLK_PIN != m_d_ff) ? 16'h0000 : inc(m_idle_ff);
        m_run_ff  <= (SRST || m_idle_ff >= 16'h0004) ? 16'h0000 : inc(m_run_ff);
        b_idle_ff <= (SRST || BCK != b_d_ff) ? 16'h0000 : inc(b_idle_ff);
        b_run_ff  <= (SRST || b_idle_ff >= 16'h0004) ? 16'h0000 : inc(b_run_ff);
        quiet_ff  <= (SRST || BCK || LRCK_PIN) ? 16'h0000 : inc(quiet_ff);
    end

    // =====================================================================
    // Properties
    // =====================================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_pll_bad; (!PLL_ENABLE || !PLL_LOCKED) [*4] ##0 rd_st; endsequence
    sequence s_pll_ok; (PLL_ENABLE && PLL_LOCKED) [*4] ##0 rd_st; endsequence
    sequence s_ign; ERROR_IGNORE_CONFIG [*4] ##0 rd_st; endsequence
    sequence s_wr_rd; (REG_WE && REG_ADDR == SA) ##1 !REG_WE ##1 (rd_st && !REG_WE); endsequence

    property p_pll_bad; s_pll_bad |=> REG_RDATA[5]; endproperty
    property p_pll_ok; s_pll_ok |=> !REG_RDATA[5]; endproperty
    property p_ign; s_ign |=> !REG_RDATA[0]; endproperty
    property p_resv;
        s_wr_rd |=> (REG_RDATA & 8'h80) == ($past(REG_WDATA, 3) & 8'h80);
    endproperty
    property p_other; REG_RE && REG_ADDR != SA |=> REG_RDATA == 8'h00; endproperty
    property p_hold; !REG_RE |=> $stable(REG_RDATA); endproperty
    property p_halt; rd_st && m_idle_ff > 16'h003c |=> REG_RDATA[6] && REG_RDATA[2]; endproperty
    property p_mrun; rd_st && m_run_ff > 16'h0064 |=> !REG_RDATA[6]; endproperty
    property p_gone;
        rd_st && int'(quiet_ff) > QUIET_MIN |=> REG_RDATA[4] && REG_RDATA[2] && REG_RDATA[1];
    endproperty
    property p_brun; rd_st && b_run_ff > 16'h0064 |=> !REG_RDATA[4]; endproperty

    a_pll_bad: assert property (p_pll_bad) else $error("pll flag clear while not locked");
    a_pll_ok: assert property (p_pll_ok) else $error("pll flag set while locked");
    a_ign: assert property (p_ign) else $error("rate flag set under ignore");
    a_resv: assert property (p_resv) else $error("reserved bit lost its write");
    a_other: assert property (p_other) else $error("unmapped read not zero");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_halt: assert property (p_halt) else $error("halted master clock not flagged");
    a_mrun: assert property (p_mrun) else $error("running master clock flagged");
    a_gone: assert property (p_gone) else $error("missing serial clocks not flagged");
    a_brun: assert property (p_brun) else $error("running bit clock flagged missing");
endmodule : acd_clock_status_asserts

bind acd_clock_status acd_clock_status_asserts #(.FRAME_MAX_CYC(FRAME_MAX_CYC)) u_chk (
    .CLK(CLK), .SRST(SRST), .BCK(BCK), .LRCK_PIN(LRCK_PIN), .MCLK_PIN(MCLK_PIN),
    .PLL_ENABLE(PLL_ENABLE), .PLL_LOCKED(PLL_LOCKED),
    .ERROR_IGNORE_CONFIG(ERROR_IGNORE_CONFIG), .REG_ADDR(REG_ADDR), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));

`default_nettype wire

// ==== tb/audio_clock_detector_status_bench.sv ====
/*
 * Bench of the clock status block: clock setup table, then special cases.
 * Assumes the source model and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none

module audio_clock_detector_status_bench;
    typedef struct {
        logic [3:0] f;
        int         bits;
        int         mr;
        int         low;
        logic [7:0] exp;
    } acd_row_t;
    localparam logic [7:0] SA = acd_pkg::CLK_DET_STATUS_ADDR;
    // Flags are PLL enable, PLL lock, serial clocks on, master clock on.
    acd_row_t rows [12] = '{
        '{4'hf, 128, 64, 64, 8'h00}, '{4'h3, 128, 64, 64, 8'h28},
        '{4'hb, 128, 64, 64, 8'h20}, '{4'h7, 256, 128, 128, 8'h20},
        '{4'hf, 256, 100, 128, 8'h0c}, '{4'hf, 257, 64, 128, 8'h02},
        '{4'hf, 128, 64, 5, 8'h04}, '{4'hf, 128, 64, 6, 8'h00},
        '{4'he, 128, 64, 64, 8'h4c}, '{4'hd, 128, 64, 64, 8'h1f},
        '{4'h0, 128, 64, 64, 8'h7f}, '{4'h3, 128, 32, 64, 8'h28}};
    logic       clk;
    logic       srst, pll_en, pll_lock, eic, re, we, run, mon;
    logic [7:0] addr, wdata, rdata, got;
    int         bits, mr, low, fails, n_tests;
    wire logic  bck, lrck, mclk;

    always #12.5 clk = ~clk;

    acd_source_model u_src (.run(run), .mclk_on(mon), .bits(bits), .mratio(mr), .low(low),
        .bck(bck), .lrck(lrck), .mclk(mclk));

    acd_clock_status #(.FRAME_MAX_CYC(600)) dut (.CLK(clk), .SRST(srst), .BCK(bck),
        .LRCK_PIN(lrck), .MCLK_PIN(mclk), .PLL_ENABLE(pll_en), .PLL_LOCKED(pll_lock),
        .ERROR_IGNORE_CONFIG(eic), .REG_ADDR(addr), .REG_WE(we), .REG_RE(re),
        .REG_WDATA(wdata), .REG_RDATA(rdata));

    // =====================================================================
    // Tasks
    // =====================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic reg_op(input logic [7:0] a, d, input logic w, r);
        @(posedge clk) #2;
        {addr, wdata, we, re} = {a, d, w, r};
        @(posedge clk) #2;
        {we, re} = 2'b00;
        got = rdata;
    endtask : reg_op

    task automatic reg_rd(input logic [7:0] a);
        reg_op(a, 8'h00, 1'b0, 1'b1);
    endtask : reg_rd

    // Polls until the masked value matches, then reads once more for the check.
    task automatic settle(input logic [7:0] m, input logic [7:0] want);
        for (int i = 0; i < 60; i++) begin
            repeat (100) @(posedge clk);
            reg_rd(SA);
            if ((got & m) === want) begin
                reg_rd(SA);
                return;
            end
        end
        fails++;
        $display("[ERR] t=%0t bound seen=%h want=%h", $time, got & m, want);
        give_verdict();
    endtask : settle

    // =====================================================================
    // Sequence
    // =====================================================================
    initial begin
        clk = 1'b0;
        {srst, pll_en, pll_lock, run, mon} = 5'h1f;
        {eic, re, we, addr, wdata} = 19'h00000;
        {bits, mr, low, fails, n_tests} = {32'd128, 32'd64, 32'd64, 64'd0};
        repeat (4) @(posedge clk);
        #2 srst = 1'b0;
        foreach (rows[i]) begin
            {pll_en, pll_lock, run, mon} = rows[i].f;
            {bits, mr, low} = {rows[i].bits, rows[i].mr, rows[i].low};
            settle(8'h7f, rows[i].exp);
            check(got & 8'h7f, rows[i].exp);
            $display("Row %0d done", i);
        end
        {pll_en, pll_lock, mr} = {2'h3, 32'd64};
        settle(8'hff, 8'h00);
        reg_op(SA, 8'hff, 1'b1, 1'b0);
        reg_rd(SA);
        check(got, 8'h80);
        reg_op(SA, 8'h00, 1'b1, 1'b1);
        check(got, 8'h80);
        reg_rd(SA);
        check(got, 8'h00);
        reg_op(8'h5d, 8'hff, 1'b1, 1'b0);
        reg_rd(8'h5d);
        check(got, 8'h00);
        $display("Register access test done");
        mon = 1'b0;
        settle(8'hff, 8'h4c);
        reg_rd(SA);
        check(got, 8'h4c);
        {mon, run, eic} = 3'h5;
        settle(8'h10, 8'h10);
        check(got & 8'h01, 8'h00);
        eic = 1'b0;
        settle(8'h01, 8'h01);
        check(got & 8'h01, 8'h01);
        $display("Ignore test done");
        srst = 1'b1;
        run = 1'b1;
        repeat (4) @(posedge clk);
        check(rdata, 8'h00);
        #2 srst = 1'b0;
        settle(8'hff, 8'h00);
        check(got, 8'h00);
        $display("Reset test done");
        give_verdict();
    end
endmodule : audio_clock_detector_status_bench

`default_nettype wire
